// File: rtl/vmt_pkg.sv
// Constants, field layouts and types of the address translation block.
// Assumes nothing beyond a SystemVerilog compiler.
package vmt_pkg;
   // =================================================================
   // Sizes
   localparam int VMT_JOINT_ENTRIES = 16;
   localparam int VMT_JIDX_W = 4;
   localparam int VMT_MICRO_ENTRIES = 4;
   localparam int VMT_MIDX_W = 2;
   localparam int VMT_WALK_MAX = 33; // Cycles from request to answer of a walk through all 16 entries

   // =================================================================
   // Address map
   localparam logic [31:0] VMT_PHYS_MASK = 32'h1fff_ffff;
   localparam logic [31:0] VMT_DSEG_BASE = 32'hff20_0000;
   localparam logic [31:0] VMT_DSEG_LAST = 32'hff3f_ffff;
   localparam logic [31:0] VMT_FIXED_USER_OFS = 32'h0000_0000;
   localparam logic [2:0] VMT_SEG_CACHED_KERNEL = 3'h4;
   localparam logic [2:0] VMT_SEG_UNCACHED_KERNEL = 3'h5;

   // =================================================================
   // Cache coherency attribute values
   localparam logic [2:0] VMT_CCA_CACHEABLE = 3'h3;
   localparam logic [2:0] VMT_CCA_RESET = 3'h2;

   // =================================================================
   // Register offsets and field positions
   localparam logic [7:0] VMT_REG_CFG = 8'h00;
   localparam logic [7:0] VMT_REG_TAG = 8'h04;
   localparam logic [7:0] VMT_REG_EVEN = 8'h08;
   localparam logic [7:0] VMT_REG_ODD = 8'h0c;
   localparam logic [7:0] VMT_REG_WRITE = 8'h10;
   localparam logic [7:0] VMT_REG_STATUS = 8'h14;
   localparam logic [7:0] VMT_REG_FAULT = 8'h18;
   localparam int VMT_CFG_K0_LSB = 0;
   localparam int VMT_CFG_KU_LSB = 3;
   localparam int VMT_CFG_K23_LSB = 6;
   localparam int VMT_CFG_UCOP_BIT = 9;
   localparam int VMT_TAG_VPN2_LSB = 13;
   localparam int VMT_LO_VALID_BIT = 31;
   localparam int VMT_ST_CAUSE_LSB = 4;
   localparam int VMT_ST_BUSY_BIT = 8;

   // =================================================================
   // Types
   typedef enum logic [1:0] {
      VMT_MODE_USER = 2'b00,
      VMT_MODE_KERNEL = 2'b01,
      VMT_MODE_DEBUG = 2'b10
   } vmt_mode_t;
   typedef enum logic [1:0] {
      VMT_S_IDLE = 2'b00,
      VMT_S_READ = 2'b01,
      VMT_S_CMP = 2'b10
   } vmt_state_t;
   typedef enum logic [1:0] {
      VMT_EXC_NONE = 2'b00,
      VMT_EXC_ADDR = 2'b01,
      VMT_EXC_MISS = 2'b10,
      VMT_EXC_INVALID = 2'b11
   } vmt_cause_t;
   localparam logic [1:0] VMT_KIND_FETCH = 2'b00;
   localparam logic [1:0] VMT_SIZE_BYTE = 2'b00;
   localparam logic [1:0] VMT_SIZE_HALF = 2'b01;
   typedef struct packed {
      logic [18:0] vpn2;
      logic [7:0] msk;
      logic v1;
      logic [19:0] pfn1;
      logic v0;
      logic [19:0] pfn0;
   } vmt_jentry_t;
endpackage

// File: rtl/vmt_entry_ram.sv
// Entry store of the joint translation buffer.
// Assumes one write and one read port on clk_sys; read data registered.
`timescale 1ns/1ps
module vmt_entry_ram #(
   parameter int WIDTH = 69,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   // Clock
   input logic clk_sys,
   // Write port
   input logic wr_en,
   input logic [AW-1:0] wr_addr,
   input logic [WIDTH-1:0] wr_data,
   // Read port
   input logic rd_en,
   input logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // Write
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Registered read
   always_ff @(posedge clk_sys) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// File: rtl/vmt_translate.sv
// Mode tracking, access checks, translation and cacheability decision.
// Assumes a pipeline on clk_sys holding each request until taken, and
// a register master issuing one-cycle strobes.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
module vmt_translate
   import vmt_pkg::*;
#(
   parameter int HAS_TLB = 1
) (
   // Clock and reset
   input logic clk_sys,
   input logic sys_rst,
   // Register port
   input logic [7:0] reg_addr,
   input logic [31:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   output logic [31:0] reg_rdata,
   // Mode events from the pipeline
   input logic debug_exc,
   input logic exc_taken,
   input logic ret_user,
   input logic ret_debug,
   // Translation request
   input logic req_valid,
   output logic req_ready,
   input logic [31:0] req_vaddr,
   input logic [1:0] req_kind,
   input logic [1:0] req_size,
   // Translation answer
   output logic rsp_valid,
   output logic [31:0] rsp_paddr,
   output logic rsp_cached,
   output logic rsp_exc,
   output logic [1:0] rsp_cause,
   output logic [3:0] rsp_byte_en,
   // Mode status
   output logic [1:0] mode,
   output logic sysctl_allowed
);
   // =================================================================
   // Declarations
   vmt_mode_t mode_q, mode_d;
   vmt_state_t state_q;
   logic [31:0] cfg_q, tag_q, even_q, odd_q, fault_q, rdata_q;
   logic [1:0] cause_q;
   logic [VMT_JOINT_ENTRIES-1:0] used_q;
   logic [VMT_JIDX_W-1:0] idx_q;
   logic [31:0] vaddr_q;
   logic bsel_q, cached_q;
   logic [2:0] cca_q;
   logic [3:0] be_q;
   logic [VMT_MIDX_W-1:0] mptr_q [2];
   logic [VMT_MICRO_ENTRIES-1:0] mhit [2];
   logic [19:0] mpfn [2][VMT_MICRO_ENTRIES];
   logic [7:0] mmsk [2][VMT_MICRO_ENTRIES];
   logic [2:0] k0, ku, k23, cca;
   logic take, breq, ram_wr, flush, dseg, mapped, cached, misalign;
   logic addr_err, fast, mic_hit, walk_go, jhit, jsel, pvalid, last;
   logic fire, inst;
   logic [19:0] mic_pfn, jpfn;
   logic [7:0] mic_msk;
   logic [8:0] onehot, excl;
   logic [31:0] fixed_pa, paddr_d;
   logic [1:0] cause_d;
   logic [1:0] addr_lo;
   vmt_jentry_t jent, went;

   function automatic logic [31:0] vmt_phys(input logic [19:0] pfn,
      input logic [7:0] msk, input logic [31:0] va);
      vmt_phys = {pfn[19:8], (pfn[7:0] & ~msk) | (va[19:12] & msk),
                  va[11:0]};
   endfunction

   function automatic logic [3:0] vmt_lanes(input logic [1:0] sz,
      input logic [1:0] a);
      case (sz)
         VMT_SIZE_BYTE: vmt_lanes = 4'h1 << a;
         VMT_SIZE_HALF: vmt_lanes = 4'h3 << {a[1], 1'b0};
         default: vmt_lanes = 4'hf;
      endcase
   endfunction

   // =================================================================
   // Segment decode of the incoming virtual address
   assign k0 = cfg_q[VMT_CFG_K0_LSB +: 3];
   assign ku = cfg_q[VMT_CFG_KU_LSB +: 3];
   assign k23 = cfg_q[VMT_CFG_K23_LSB +: 3];
   assign take = req_valid && req_ready;
   assign breq = (req_kind != VMT_KIND_FETCH);
   assign addr_lo = req_vaddr[1:0];
   assign dseg = (mode_q == VMT_MODE_DEBUG) && (req_vaddr >= VMT_DSEG_BASE)
                 && (req_vaddr <= VMT_DSEG_LAST);
   assign mapped = !dseg && (!req_vaddr[31] || (req_vaddr[31:30] == 2'b11));
   assign misalign = (req_size == VMT_SIZE_HALF) ? req_vaddr[0] :
                     (req_size != VMT_SIZE_BYTE) && (addr_lo != 2'b00);
   assign addr_err = ((mode_q == VMT_MODE_USER) && req_vaddr[31])
                     || misalign;

   // Attribute governing the segment, chosen from the virtual address
   always_comb begin
      if (dseg || req_vaddr[31:29] == VMT_SEG_UNCACHED_KERNEL) begin
         cca = VMT_CCA_RESET;
      end else if (!req_vaddr[31]) begin
         cca = ku;
      end else if (req_vaddr[31:29] == VMT_SEG_CACHED_KERNEL) begin
         cca = k0;
      end else begin
         cca = k23;
      end
   end
   assign cached = (cca == VMT_CCA_CACHEABLE);

   // Fixed mapping for unmapped segments and the buffer-less variant
   always_comb begin
      if (dseg) begin
         fixed_pa = req_vaddr;
      end else if (req_vaddr[31:30] == 2'b10) begin
         fixed_pa = req_vaddr & VMT_PHYS_MASK;
      end else if (!req_vaddr[31]) begin
         fixed_pa = req_vaddr + VMT_FIXED_USER_OFS;
      end else begin
         fixed_pa = req_vaddr;
      end
   end

   // =================================================================
   // Micro buffers: instruction (0) and data (1), four entries each
   genvar gb, ge;
   generate
      for (gb = 0; gb < 2; gb++) begin : g_buf
         for (ge = 0; ge < VMT_MICRO_ENTRIES; ge++) begin : g_ent
            logic v_q;
            logic [19:0] vpn_q, pfn_q;
            logic [7:0] msk_q;
            assign mhit[gb][ge] = v_q && (((req_vaddr[31:12] ^ vpn_q)
                                  & ~{12'h000, msk_q}) == 20'h00000);
            assign mpfn[gb][ge] = pfn_q;
            assign mmsk[gb][ge] = msk_q;
            // Refill from the joint buffer, flush on any entry write
            always_ff @(posedge clk_sys) begin
               if (sys_rst || flush) begin
                  v_q <= 1'b0;
               end else if (inst && bsel_q == 1'(gb)
                            && mptr_q[gb] == VMT_MIDX_W'(ge)) begin
                  v_q <= 1'b1;
                  vpn_q <= vaddr_q[31:12] & ~{12'h000, jent.msk};
                  msk_q <= jent.msk;
                  pfn_q <= jpfn;
               end
            end
         end
      end
   endgenerate

   // Hit selection within the buffer for this kind of access
   always_comb begin
      mic_hit = 1'b0;
      mic_pfn = 20'h00000;
      mic_msk = 8'h00;
      for (int e = 0; e < VMT_MICRO_ENTRIES; e++) begin
         if (mhit[breq][e]) begin
            mic_hit = 1'b1;
            mic_pfn = mpfn[breq][e];
            mic_msk = mmsk[breq][e];
         end
      end
   end

   // Round-robin replacement pointer per micro buffer
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mptr_q[0] <= '0;
         mptr_q[1] <= '0;
      end else if (inst) begin
         mptr_q[bsel_q] <= mptr_q[bsel_q] + VMT_MIDX_W'(1);
      end
   end

   // =================================================================
   // Joint buffer entry store and compare
   assign went = '{vpn2: tag_q[VMT_TAG_VPN2_LSB +: 19], msk: tag_q[7:0],
                   v1: odd_q[VMT_LO_VALID_BIT], pfn1: odd_q[19:0],
                   v0: even_q[VMT_LO_VALID_BIT], pfn0: even_q[19:0]};

   vmt_entry_ram #(
      .WIDTH($bits(vmt_jentry_t)),
      .DEPTH(VMT_JOINT_ENTRIES),
      .AW(VMT_JIDX_W)
   ) u_ram (
      .clk_sys(clk_sys),
      .wr_en(ram_wr),
      .wr_addr(reg_wdata[VMT_JIDX_W-1:0]),
      .wr_data(went),
      .rd_en(state_q == VMT_S_READ),
      .rd_addr(idx_q),
      .rd_data(jent)
   );

   // Page size from the mask: lowest unmasked bit picks even or odd page
   assign onehot = {1'b0, jent.msk} + 9'h001;
   assign excl = {1'b0, jent.msk} | onehot;
   assign jsel = |(vaddr_q[20:12] & onehot);
   assign jhit = used_q[idx_q] && (((vaddr_q[31:13] ^ jent.vpn2)
                 & ~{11'h000, excl[8:1]}) == 19'h00000);
   assign pvalid = jsel ? jent.v1 : jent.v0;
   assign jpfn = jsel ? jent.pfn1 : jent.pfn0;
   assign last = (idx_q == VMT_JIDX_W'(VMT_JOINT_ENTRIES - 1));
   assign inst = (state_q == VMT_S_CMP) && jhit && pvalid;

   // =================================================================
   // Request flow
   assign req_ready = (state_q == VMT_S_IDLE);
   assign fast = !mapped || (HAS_TLB == 0);
   assign walk_go = take && !addr_err && !fast && !mic_hit;

   // Answer selection for the fast path and for the walk
   always_comb begin
      fire = 1'b0;
      cause_d = VMT_EXC_NONE;
      paddr_d = 32'h0000_0000;
      if (state_q == VMT_S_IDLE) begin
         fire = take && !walk_go;
         if (addr_err) begin
            cause_d = VMT_EXC_ADDR;
         end else if (fast) begin
            paddr_d = fixed_pa;
         end else begin
            paddr_d = vmt_phys(mic_pfn, mic_msk, req_vaddr);
         end
      end else if (state_q == VMT_S_CMP) begin
         fire = jhit || last;
         if (jhit && pvalid) begin
            paddr_d = vmt_phys(jpfn, jent.msk, vaddr_q);
         end else if (jhit) begin
            cause_d = VMT_EXC_INVALID;
         end else begin
            cause_d = VMT_EXC_MISS;
         end
      end
   end

   // Walk state machine
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q <= VMT_S_IDLE;
         idx_q <= '0;
      end else begin
         case (state_q)
            VMT_S_IDLE: begin
               idx_q <= '0;
               if (walk_go) begin
                  state_q <= VMT_S_READ;
               end
            end
            VMT_S_READ: begin
               state_q <= VMT_S_CMP;
            end
            VMT_S_CMP: begin
               if (fire) begin
                  state_q <= VMT_S_IDLE;
               end else begin
                  idx_q <= idx_q + VMT_JIDX_W'(1);
                  state_q <= VMT_S_READ;
               end
            end
            default: begin
               state_q <= VMT_S_IDLE;
            end
         endcase
      end
   end

   // Request capture; cacheability is settled from the virtual address
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         vaddr_q <= 32'h0000_0000;
         bsel_q <= 1'b0;
         cached_q <= 1'b0;
         cca_q <= VMT_CCA_RESET;
         be_q <= 4'h0;
      end else if (take) begin
         vaddr_q <= req_vaddr;
         bsel_q <= breq;
         cached_q <= cached;
         cca_q <= cca;
         be_q <= vmt_lanes(req_size, addr_lo);
      end
   end

   // Answer registers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rsp_valid <= 1'b0;
         rsp_paddr <= 32'h0000_0000;
         rsp_cached <= 1'b0;
         rsp_exc <= 1'b0;
         rsp_cause <= VMT_EXC_NONE;
         rsp_byte_en <= 4'h0;
      end else begin
         rsp_valid <= fire;
         if (fire) begin
            rsp_paddr <= paddr_d;
            rsp_exc <= (cause_d != VMT_EXC_NONE);
            rsp_cause <= cause_d;
            if (state_q == VMT_S_IDLE) begin
               rsp_cached <= cached && (cause_d == VMT_EXC_NONE);
               rsp_byte_en <= vmt_lanes(req_size, addr_lo);
            end else begin
               rsp_cached <= cached_q && (cause_d == VMT_EXC_NONE);
               rsp_byte_en <= be_q;
            end
         end
      end
   end

   // =================================================================
   // Operating mode
   always_comb begin
      mode_d = mode_q;
      if (debug_exc) begin
         mode_d = VMT_MODE_DEBUG;
      end else if (exc_taken || (fire && cause_d != VMT_EXC_NONE)) begin
         if (mode_q != VMT_MODE_DEBUG) begin
            mode_d = VMT_MODE_KERNEL;
         end
      end else if (ret_debug && mode_q == VMT_MODE_DEBUG) begin
         mode_d = VMT_MODE_KERNEL;
      end else if (ret_user && mode_q == VMT_MODE_KERNEL) begin
         mode_d = VMT_MODE_USER;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mode_q <= VMT_MODE_KERNEL;
      end else begin
         mode_q <= mode_d;
      end
   end
   assign mode = mode_q;
   assign sysctl_allowed = (mode_q != VMT_MODE_USER)
                           || cfg_q[VMT_CFG_UCOP_BIT];

   // =================================================================
   // Register port
   assign ram_wr = reg_wr && (reg_addr == VMT_REG_WRITE);
   assign flush = ram_wr;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cfg_q <= {22'h0, 1'b0, VMT_CCA_RESET, VMT_CCA_RESET, VMT_CCA_RESET};
         tag_q <= 32'h0000_0000;
         even_q <= 32'h0000_0000;
         odd_q <= 32'h0000_0000;
         used_q <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            VMT_REG_CFG: cfg_q <= {22'h0, reg_wdata[9:0]};
            VMT_REG_TAG: tag_q <= reg_wdata & 32'hffff_e0ff;
            VMT_REG_EVEN: even_q <= reg_wdata & 32'h800f_ffff;
            VMT_REG_ODD: odd_q <= reg_wdata & 32'h800f_ffff;
            VMT_REG_WRITE: used_q[reg_wdata[VMT_JIDX_W-1:0]] <= 1'b1;
            default: begin
            end
         endcase
      end
   end

   // Fault capture for software
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         fault_q <= 32'h0000_0000;
         cause_q <= VMT_EXC_NONE;
      end else if (fire && cause_d != VMT_EXC_NONE) begin
         fault_q <= (state_q == VMT_S_IDLE) ? req_vaddr : vaddr_q;
         cause_q <= cause_d;
      end
   end

   // Read data stand one cycle after the strobe only
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !reg_rd) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         case (reg_addr)
            VMT_REG_CFG: rdata_q <= cfg_q;
            VMT_REG_TAG: rdata_q <= tag_q;
            VMT_REG_EVEN: rdata_q <= even_q;
            VMT_REG_ODD: rdata_q <= odd_q;
            VMT_REG_STATUS: rdata_q <= {23'h0, state_q != VMT_S_IDLE,
                                        2'b00, cause_q, 2'b00, mode_q};
            VMT_REG_FAULT: rdata_q <= fault_q;
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end
   assign reg_rdata = rdata_q;

   // =================================================================
   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   property p_reset_kernel;
      $fell(sys_rst) |-> mode_q == VMT_MODE_KERNEL;
   endproperty
   a_reset_kernel: assert property (p_reset_kernel)
      else $error("mode not kernel after reset");

   property p_user_limit;
      take && mode_q == VMT_MODE_USER && req_vaddr[31]
         |=> rsp_valid && rsp_exc && rsp_cause == VMT_EXC_ADDR;
   endproperty
   a_user_limit: assert property (p_user_limit)
      else $error("user access above 2 GB not refused");

   property p_exc_kernel;
      rsp_valid && rsp_exc && $past(mode_q) != VMT_MODE_DEBUG
         && !$past(debug_exc) |-> mode_q == VMT_MODE_KERNEL;
   endproperty
   a_exc_kernel: assert property (p_exc_kernel)
      else $error("exception did not enter kernel mode");

   property p_uncached_seg;
      take && mode_q != VMT_MODE_USER && !misalign
         && req_vaddr[31:29] == VMT_SEG_UNCACHED_KERNEL
         |=> rsp_valid && !rsp_cached
         && rsp_paddr == ($past(req_vaddr) & VMT_PHYS_MASK);
   endproperty
   a_uncached_seg: assert property (p_uncached_seg)
      else $error("uncached kernel access wrong");

   property p_micro_first;
      take && !addr_err && !fast && mic_hit
         |=> rsp_valid && !rsp_exc ##1 (!rsp_valid || $past(take));
   endproperty
   a_micro_first: assert property (p_micro_first)
      else $error("micro buffer hit not answered at once");

   property p_walk_bound;
      walk_go |=> !rsp_valid ##1 !rsp_valid ##[1:31] rsp_valid;
   endproperty
   a_walk_bound: assert property (p_walk_bound)
      else $error("joint buffer walk not answered in time");

   property p_cached_011;
      rsp_valid && rsp_cached |-> cca_q == VMT_CCA_CACHEABLE;
   endproperty
   a_cached_011: assert property (p_cached_011)
      else $error("cached answer without attribute 011");

   property p_byte_lane;
      take && req_size == VMT_SIZE_BYTE && !addr_err
         |=> be_q == (4'h1 << $past(addr_lo))
         && (!rsp_valid || rsp_byte_en == be_q);
   endproperty
   a_byte_lane: assert property (p_byte_lane)
      else $error("byte lane not little-endian");
endmodule

// File: tb/vmt_pipe_model.sv
// ==========================================================
// Pipeline model issuing fetch, load and store translations
// Assumes the translation block's request/answer handshake on clk_sys
`timescale 1ns/1ps
module vmt_pipe_model (
   // Clock
   input logic clk_sys,
   // Request
   output logic req_valid,
   input logic req_ready,
   output logic [31:0] req_vaddr,
   output logic [1:0] req_kind,
   output logic [1:0] req_size,
   // Answer
   input logic rsp_valid
);
   int lat;
   logic tmo;
   // Idle bus at time zero
   initial begin
      req_valid = 1'b0;
      req_vaddr = 32'h0;
      req_kind = 2'h0;
      req_size = 2'h0;
      tmo = 1'b0;
      lat = 0;
   end
   // Hold request until taken, then time the answer in cycles
   task automatic access(input logic [31:0] va, input logic [1:0] k,
                         input logic [1:0] s);
      int n;
      n = 0;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_vaddr <= va;
      req_kind <= k;
      req_size <= s;
      #1;
      while (!req_ready && n < 60) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      @(posedge clk_sys);
      // Released address is scrambled so stale values never match
      req_valid <= 1'b0;
      req_vaddr <= ~va;
      req_kind <= ~k;
      // A fast answer stands only in the cycle after the taking edge
      lat = 1;
      #1;
      while (!rsp_valid && lat < 40) begin
         @(posedge clk_sys);
         #1;
         lat++;
      end
      if (n >= 60 || lat >= 40) tmo = 1'b1;
   endtask
endmodule

// File: tb/tb_top.sv
// ==========================================================
// Self-checking bench of the address translation block
// Assumes the pipeline model beside it and one 250 MHz clock
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
   import vmt_pkg::*;
   logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rsp_paddr, rd_q;
   logic debug_exc = 1'b0, exc_taken = 1'b0, ret_user = 1'b0;
   logic ret_debug = 1'b0, req_valid, req_ready, rsp_valid, rsp_cached;
   logic rsp_exc, sysctl_allowed;
   logic [31:0] req_vaddr;
   logic [1:0] req_kind, req_size, rsp_cause, mode;
   logic [3:0] rsp_byte_en;
   int fails = 0, n_tests = 0;
   // Clock
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   // Design and pipeline model
   vmt_translate u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .debug_exc(debug_exc),
      .exc_taken(exc_taken), .ret_user(ret_user), .ret_debug(ret_debug),
      .req_valid(req_valid), .req_ready(req_ready), .req_vaddr(req_vaddr),
      .req_kind(req_kind), .req_size(req_size), .rsp_valid(rsp_valid),
      .rsp_paddr(rsp_paddr), .rsp_cached(rsp_cached), .rsp_exc(rsp_exc),
      .rsp_cause(rsp_cause), .rsp_byte_en(rsp_byte_en), .mode(mode),
      .sysctl_allowed(sysctl_allowed));
   vmt_pipe_model u_pipe (.clk_sys(clk_sys), .req_valid(req_valid),
      .req_ready(req_ready), .req_vaddr(req_vaddr), .req_kind(req_kind),
      .req_size(req_size), .rsp_valid(rsp_valid));
   // Register write, one strobe cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // Register read, data sampled in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      rd_q = reg_rdata;
   endtask
   // Load one joint entry and commit it
   task automatic prog(input logic [3:0] i, input logic [31:0] t, ev);
      wr(VMT_REG_TAG, t);
      wr(VMT_REG_EVEN, ev);
      wr(VMT_REG_ODD, 32'h0);
      wr(VMT_REG_WRITE, {28'h0, i});
   endtask
   // One mode event pulse: 0 debug, 1 exception, 2 leave debug, 3 user
   task automatic ev(input int w);
      @(posedge clk_sys);
      {ret_user, ret_debug, exc_taken, debug_exc} <= 4'h1 << w;
      @(posedge clk_sys);
      {ret_user, ret_debug, exc_taken, debug_exc} <= 4'h0;
      #1;
   endtask
   // Answer check: latency, address, cacheability, exception, cause
   task automatic chk(input int l, input logic [31:0] p, input logic c,
                      input logic [1:0] ca);
      `CHK("latency", l, u_pipe.lat)
      `CHK("paddr", p, rsp_paddr)
      `CHK("cached", c, rsp_cached)
      `CHK("exc", (ca != 2'h0), rsp_exc)
      `CHK("cause", ca, rsp_cause)
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      #1;
      `CHK("mode", 2'b01, mode)
      `CHK("sysctl", 1'b1, sysctl_allowed)
      rd(VMT_REG_CFG);
      `CHK("cfg", 32'h092, rd_q)
      wr(VMT_REG_CFG, 32'h09b);
      u_pipe.access(32'h8000_1234, 2'h1, 2'h2);
      chk(1, 32'h0000_1234, 1'b1, 2'h0);
      `CHK("byte_en", 4'hf, rsp_byte_en)
      u_pipe.access(32'ha000_1234, 2'h2, 2'h2);
      chk(1, 32'h0000_1234, 1'b0, 2'h0);
      u_pipe.access(32'hc000_0000, 2'h1, 2'h2);
      chk(VMT_WALK_MAX, 32'h0, 1'b0, 2'h2);
      $display("test unmapped and miss done");
      // Entries loaded only after unmapped accesses and one mapped miss so far
      prog(4'h0, 32'h0040_0000, 32'h8000_0123);
      prog(4'h1, 32'h0060_00ff, 32'h8000_0500);
      ev(3);
      `CHK("mode", 2'b00, mode)
      `CHK("sysctl", 1'b0, sysctl_allowed)
      u_pipe.access(32'h0040_0010, VMT_KIND_FETCH, 2'h2);
      chk(3, 32'h0012_3010, 1'b1, 2'h0);
      u_pipe.access(32'h0040_0010, VMT_KIND_FETCH, 2'h2);
      chk(1, 32'h0012_3010, 1'b1, 2'h0);
      u_pipe.access(32'h0040_0011, 2'h1, VMT_SIZE_BYTE);
      chk(3, 32'h0012_3011, 1'b1, 2'h0);
      `CHK("byte_en", 4'h2, rsp_byte_en)
      u_pipe.access(32'h0061_2346, 2'h1, VMT_SIZE_HALF);
      chk(5, 32'h0051_2346, 1'b1, 2'h0);
      `CHK("byte_en", 4'hc, rsp_byte_en)
      u_pipe.access(32'h8000_0000, 2'h1, 2'h2);
      chk(1, 32'h0, 1'b0, 2'h1);
      @(posedge clk_sys);
      #1;
      `CHK("mode", 2'b01, mode)
      // Odd page of entry 0 was never made valid
      u_pipe.access(32'h0040_1010, 2'h1, 2'h2);
      chk(3, 32'h0, 1'b0, 2'h3);
      $display("test mapped and user done");
      ev(3);
      ev(1);
      `CHK("mode", 2'b01, mode)
      ev(0);
      `CHK("mode", 2'b10, mode)
      u_pipe.access(32'hff20_0010, 2'h1, 2'h2);
      chk(1, 32'hff20_0010, 1'b0, 2'h0);
      u_pipe.access(32'h8000_0040, 2'h1, 2'h2);
      chk(1, 32'h0000_0040, 1'b1, 2'h0);
      ev(2);
      `CHK("mode", 2'b01, mode)
      rd(8'h40);
      `CHK("unmapped", 32'h0, rd_q)
      rd(VMT_REG_STATUS);
      `CHK("status", 32'h0000_0031, rd_q)
      rd(VMT_REG_FAULT);
      `CHK("fault", 32'h0040_1010, rd_q)
      `CHK("timeout", 1'b0, u_pipe.tmo)
      $display("test modes and registers done");
      results();
   end
endmodule
